// File: pkg/hbw_pkg.sv
/*
  Constants and carrier types for the host bus word assembly port.
  Assumes a single 100 MHz clock and a synchronous active-low reset.
*/
package hbw_pkg;
  localparam int HBW_ADDR_W = 4;
  localparam int HBW_WORD_W = 28;
  localparam int HBW_HALF_W = 16;
  localparam int HBW_REGS = 16;
  localparam logic [3:0] HBW_ADR_CFG4 = 4'h4;
  localparam logic [3:0] HBW_ADR_FIFO1 = 4'h8;
  localparam logic [3:0] HBW_ADR_FIFO2 = 4'h9;
  localparam logic [3:0] HBW_ADR_BUS16 = 4'he;
  localparam int HBW_BUS16_BIT = 4;
  localparam int HBW_MRESET_BIT = 22;
  localparam int HBW_ALUTRIG_BIT = 24;
  localparam int HBW_QUIET_BIT = 25;
  localparam int HBW_RESULT_W = 23;
  localparam logic [27:0] HBW_REG_RST = 28'h0000000;
  localparam int HBW_PROC_NS = 900;
  localparam int HBW_CLK_MHZ = 100;
  localparam int HBW_PROC_CYC = (HBW_PROC_NS * HBW_CLK_MHZ + 999) / 1000;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] addr;
    logic [15:0] data;
  } hbw_bus_t;

  typedef enum logic [1:0] {
    HBW_IDLE = 2'b00,
    HBW_WAIT = 2'b01,
    HBW_PROC = 2'b10
  } hbw_state_t;
endpackage

// File: src/hbw_regfile.sv
/*
  Sixteen-entry register store of 28-bit words, registered read data.
  Assumes writes and reads come from the port logic on the same clock.
*/
`timescale 1ns/1ps
module hbw_regfile
  import hbw_pkg::*;
#(
  parameter int DEPTH = HBW_REGS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Write side
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [27:0] wdata,
  // Read side
  input wire logic [3:0] raddr,
  output logic [27:0] rdata
);
  initial
  begin
    if (DEPTH != 16)
      $error("DEPTH must be 16 for a 4-bit address");
  end

  logic [27:0] mem_r [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_ent
      always_ff @(posedge clk)
      begin
        if (!nrst)
          mem_r[gi] <= HBW_REG_RST;
        else if (we && waddr == 4'(gi))
          mem_r[gi] <= wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata <= HBW_REG_RST;
    else
      rdata <= mem_r[raddr];
  end
endmodule

// File: src/hbw_port.sv
/*
  Parallel host port: single 16-bit or 2x16-bit word assembly with chip-select
  gated latch pointer, master reset, deferred processing trigger and
  result readout. Assumes host strobes and select are asynchronous pins.
*/
// Overview of operation
// - Register 14 bit 4 selects 16-bit bus
// - Each selected strobe in 16-bit mode flips low/high latch pointer
// - Pointer frozen while chip select high
// - Deselected strobes store no data
// - Leaving 16-bit mode resets pointer low
// - Result spans 2^23 fine bins
// - Master reset keeps configuration registers
// - Deferred processing waits for trigger
// - Buffer one at 8, two at 9
`timescale 1ns/1ps
module hbw_port
  import hbw_pkg::*;
#(
  parameter int PROC_CYC = HBW_PROC_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Host bus pins
  input wire logic chip_select_low,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic [3:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  // Measurement core side
  input wire logic alu_trigger_pin,
  input wire logic [22:0] meas_result1,
  input wire logic [22:0] meas_result2,
  input wire logic meas_ready,
  // Status
  output logic buffer_empty_flag,
  output logic bus16_mode,
  output logic master_reset_pulse
);
  initial
  begin
    if (PROC_CYC < 1 || PROC_CYC > 65535)
      $error("PROC_CYC must fit the 16-bit countdown");
  end

  hbw_bus_t s1_r, s2_r, s3_r;
  logic trg1_r, trg2_r, trg3_r;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 16'h0000};
      s2_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 16'h0000};
      s3_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 4'h0, data: 16'h0000};
      trg1_r <= 1'b0;
      trg2_r <= 1'b0;
      trg3_r <= 1'b0;
    end
    else
    begin
      s1_r <= '{cs_n: chip_select_low, rd_n: read_strobe_low, wr_n: write_strobe_low,
                addr: addr, data: data_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      trg1_r <= alu_trigger_pin;
      trg2_r <= trg1_r;
      trg3_r <= trg2_r;
    end
  end

  // Act on strobe release so data has settled; select sampled alongside
  wire logic rd_end = !s3_r.rd_n && s2_r.rd_n;
  wire logic wr_end = !s3_r.wr_n && s2_r.wr_n;
  wire logic sel = !s3_r.cs_n;
  wire logic acc_rd = rd_end && sel;
  wire logic acc_wr = wr_end && sel;

  logic mode16_r;
  logic ptr_hi_r;
  logic [15:0] low_r;
  logic [27:0] rd_word;
  logic [27:0] cfg4_q;
  logic full_we;
  logic [27:0] full_wd;

  wire logic [27:0] wr_assembled = mode16_r ? {s3_r.data[11:0], low_r} : {12'h000, s3_r.data};
  always_comb
  begin
    full_we = acc_wr && (!mode16_r || ptr_hi_r);
    full_wd = wr_assembled;
  end

  // Only the select-gated access moves the pointer, fixing the stray toggle
  always_ff @(posedge clk)
  begin
    if (!nrst || !mode16_r)
      ptr_hi_r <= 1'b0;
    else if (acc_rd || acc_wr)
      ptr_hi_r <= !ptr_hi_r;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      low_r <= 16'h0000;
    else if (acc_wr && mode16_r && !ptr_hi_r)
      low_r <= s3_r.data;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      mode16_r <= 1'b0;
    else if (full_we && s3_r.addr == HBW_ADR_BUS16)
      mode16_r <= full_wd[HBW_BUS16_BIT];
  end

  hbw_regfile #(.DEPTH(HBW_REGS)) u_regs (
    .clk(clk),
    .nrst(nrst),
    .we(full_we),
    .waddr(s3_r.addr),
    .wdata(full_wd),
    .raddr(HBW_ADR_CFG4),
    .rdata(cfg4_q)
  );

  // Master reset and software trigger from a register 4 write
  wire logic wr4 = full_we && s3_r.addr == HBW_ADR_CFG4;
  wire logic mreset = wr4 && full_wd[HBW_MRESET_BIT];
  wire logic sw_trig = wr4 && full_wd[HBW_ALUTRIG_BIT];
  wire logic quiet = cfg4_q[HBW_QUIET_BIT];
  wire logic trig = sw_trig || (trg2_r && !trg3_r);

  hbw_state_t st_r;
  logic [15:0] cnt_r;
  logic [22:0] res1_r, res2_r;
  logic [1:0] full_r;
  always_ff @(posedge clk)
  begin
    if (!nrst || mreset)
    begin
      st_r <= HBW_IDLE;
      cnt_r <= 16'h0000;
      res1_r <= 23'h000000;
      res2_r <= 23'h000000;
      full_r <= 2'b00;
    end
    else
    begin
      // Read clear first, so a result landing in the same cycle wins
      if (acc_rd && (!mode16_r || ptr_hi_r))
      begin
        if (s3_r.addr == HBW_ADR_FIFO1)
          full_r[0] <= 1'b0;
        else if (s3_r.addr == HBW_ADR_FIFO2)
          full_r[1] <= 1'b0;
      end
      unique case (st_r)
        HBW_IDLE:
          if (meas_ready)
          begin
            res1_r <= meas_result1;
            res2_r <= meas_result2;
            st_r <= quiet ? HBW_WAIT : HBW_PROC;
            cnt_r <= 16'(PROC_CYC);
          end
        HBW_WAIT:
          if (trig)
            st_r <= HBW_PROC;
        HBW_PROC:
          if (cnt_r <= 16'h0001)
          begin
            full_r <= 2'b11;
            st_r <= HBW_IDLE;
          end
          else
            cnt_r <= cnt_r - 16'h0001;
      endcase
    end
  end

  always_comb
  begin
    unique case (s2_r.addr)
      HBW_ADR_FIFO1: rd_word = {5'h00, res1_r};
      HBW_ADR_FIFO2: rd_word = {5'h00, res2_r};
      default: rd_word = 28'h0000000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      data_out <= 16'h0000;
      data_oe <= 1'b0;
      buffer_empty_flag <= 1'b1;
      bus16_mode <= 1'b0;
      master_reset_pulse <= 1'b0;
    end
    else
    begin
      data_out <= (mode16_r && ptr_hi_r) ? {4'h0, rd_word[27:16]} : rd_word[15:0];
      data_oe <= !s2_r.cs_n && !s2_r.rd_n;
      buffer_empty_flag <= !full_r[0];
      bus16_mode <= mode16_r;
      master_reset_pulse <= mreset;
    end
  end

  ptr_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    (s3_r.cs_n && mode16_r && !mreset) |=> $stable(ptr_hi_r))
    else $error("pointer toggled while deselected");
  ptr_flip_a: assert property (@(posedge clk) disable iff (!nrst)
    (acc_wr && mode16_r && $past(mode16_r)) |=> (ptr_hi_r != $past(ptr_hi_r) || !mode16_r))
    else $error("pointer did not flip on access");
  ptr_off_a: assert property (@(posedge clk) disable iff (!nrst)
    !mode16_r |=> !ptr_hi_r)
    else $error("pointer not low outside 16-bit mode");
  no_store_a: assert property (@(posedge clk) disable iff (!nrst)
    s3_r.cs_n |-> !full_we)
    else $error("store while deselected");
  mode_set_a: assert property (@(posedge clk) disable iff (!nrst)
    (full_we && s3_r.addr == HBW_ADR_BUS16) |=> mode16_r == $past(full_wd[HBW_BUS16_BIT]))
    else $error("bus width not updated");
  wait_trig_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == HBW_WAIT && !trig && !mreset) |=> st_r == HBW_WAIT)
    else $error("processing began without trigger");
  mreset_clr_a: assert property (@(posedge clk) disable iff (!nrst)
    mreset |=> (st_r == HBW_IDLE && full_r == 2'b00 ##1 buffer_empty_flag))
    else $error("master reset did not clear state");
  half_low_a: assert property (@(posedge clk) disable iff (!nrst)
    (acc_wr && mode16_r && !ptr_hi_r) |=> low_r == $past(s3_r.data))
    else $error("low half-word not latched");
  cov16_c: cover property (@(posedge clk) disable iff (!nrst) full_we && mode16_r);
  covtrig_c: cover property (@(posedge clk) disable iff (!nrst) st_r == HBW_WAIT ##1 st_r == HBW_PROC);
  covdesel_c: cover property (@(posedge clk) disable iff (!nrst) wr_end && !sel && mode16_r);
endmodule

// File: bench/hbw_host.sv
/*
  Host processor model: strobed bus cycles, whole 28-bit words as two halves.
  Assumes the bench calls its tasks and that clk is the port clock.
*/
`timescale 1ns/1ps
module hbw_host
  import hbw_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bus pins and read data
  output hbw_bus_t bus,
  input wire logic [15:0] rdata
);
  initial bus = {1'b1, 1'b1, 1'b1, 4'h0, 16'h0};

  // Select stays low well around the strobe, so the synchronised copy covers it
  task automatic cyc(input logic sel, input logic rd, input logic [3:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk);
    bus.cs_n <= ~sel;
    bus.addr <= a;
    bus.data <= d;
    repeat (3) @(posedge clk);
    if (rd)
      bus.rd_n <= 1'b0;
    else
      bus.wr_n <= 1'b0;
    repeat (6) @(posedge clk);
    q = rdata;
    bus.rd_n <= 1'b1;
    bus.wr_n <= 1'b1;
    repeat (6) @(posedge clk);
    bus.cs_n <= 1'b1;
    // Released data must not keep its last value
    bus.data <= ~d;
    repeat (3) @(posedge clk);
  endtask

  task automatic wr28(input logic [3:0] a, input logic [27:0] v);
    logic [15:0] q;
    cyc(1'b1, 1'b0, a, v[15:0], q);
    cyc(1'b1, 1'b0, a, {4'h0, v[27:16]}, q);
  endtask

  task automatic rd28(input logic [3:0] a, output logic [31:0] r);
    logic [15:0] lo;
    logic [15:0] hi;
    cyc(1'b1, 1'b1, a, 16'h0, lo);
    cyc(1'b1, 1'b1, a, 16'h0, hi);
    r = {hi, lo};
  endtask
endmodule

// File: bench/host_bus_word_assembly_tb.sv
/*
  Self-checking bench for the host port: alignment, word assembly, shots.
  Assumes a 100 MHz clock and the host model driving the bus pins.
*/
`timescale 1ns/1ps
module host_bus_word_assembly_tb;
  import hbw_pkg::*;
  logic clk, nrst, alu_trigger_pin, meas_ready, data_oe, buffer_empty_flag, bus16_mode, master_reset_pulse;
  logic [22:0] meas_result1, meas_result2, m1, m2;
  logic [15:0] data_out, q, p, lfsr_r;
  logic [27:0] w;
  logic [31:0] r;
  hbw_bus_t bus;
  int fail_count = 0;
  int n_checks = 0;
  int mr_count = 0;
  int oe_cnt = 0;
  int n;

  hbw_host u_host (.clk(clk), .bus(bus), .rdata(data_out));
  hbw_port #(.PROC_CYC(2)) u_dut (.clk(clk), .nrst(nrst), .chip_select_low(bus.cs_n),
    .read_strobe_low(bus.rd_n), .write_strobe_low(bus.wr_n), .addr(bus.addr), .data_in(bus.data),
    .data_out(data_out), .data_oe(data_oe), .alu_trigger_pin(alu_trigger_pin),
    .meas_result1(meas_result1), .meas_result2(meas_result2), .meas_ready(meas_ready),
    .buffer_empty_flag(buffer_empty_flag), .bus16_mode(bus16_mode), .master_reset_pulse(master_reset_pulse));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Expected half-word of a 28-bit value as the port hands it out
  function automatic logic [15:0] halfw(input logic [27:0] v, input logic hi);
    return hi ? {4'h0, v[27:16]} : v[15:0];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
    if (master_reset_pulse === 1'b1)
      mr_count++;

  always @(posedge clk)
    if (data_oe === 1'b1)
      oe_cnt++;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    final_report();
  end

  initial
  begin
    nrst = 1'b0;
    alu_trigger_pin = 1'b0;
    meas_ready = 1'b0;
    meas_result1 = 23'h0;
    meas_result2 = 23'h0;
    lfsr_r = 16'h0017;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk({15'h0, bus16_mode}, 16'h0);
    chk({15'h0, buffer_empty_flag}, 16'h1);
    u_host.cyc(1'b1, 1'b0, 4'h3, lfsr_r, q);
    chk(u_dut.u_regs.mem_r[3][15:0], lfsr_r);
    n = oe_cnt;
    // Strobe is held low for six clocks, so the driver enable counts six
    u_host.cyc(1'b1, 1'b1, 4'h3, 16'h0, q);
    chk(16'(oe_cnt - n), 16'h0006);
    // Stray low half leaves the pointer on the high latch
    u_host.cyc(1'b1, 1'b0, HBW_ADR_BUS16, 16'h0010, q);
    u_host.cyc(1'b1, 1'b0, 4'h3, 16'h1234, q);
    u_host.cyc(1'b1, 1'b0, 4'hf, 16'h0000, q);
    u_host.cyc(1'b1, 1'b0, HBW_ADR_BUS16, 16'h0000, q);
    u_host.cyc(1'b1, 1'b0, HBW_ADR_BUS16, 16'h0000, q);
    chk({15'h0, bus16_mode}, 16'h0);
    u_host.cyc(1'b1, 1'b0, HBW_ADR_BUS16, 16'h0010, q);
    chk({15'h0, bus16_mode}, 16'h1);
    $display("test align done");
    for (int i = 0; i < 6; i++)
    begin
      lfsr_r = lfsr_next(lfsr_r);
      p = lfsr_r;
      lfsr_r = lfsr_next(lfsr_r);
      w = {lfsr_r[11:0], p};
      if (i == 0)
        w = 28'hfffffff;
      u_host.wr28(i[0] ? 4'h3 : 4'h7, w);
      if (i == 2)
      begin
        n = oe_cnt;
        u_host.cyc(1'b0, 1'b1, 4'h3, 16'hffff, q);
        chk(16'(oe_cnt - n), 16'h0000);
      end
      if (i == 3)
        u_host.cyc(1'b0, 1'b0, 4'h3, ~w[15:0], q);
      // Configuration words are not read back on the bus, so look at the store
      r = {4'h0, u_dut.u_regs.mem_r[i[0] ? 3 : 7]};
      chk(r[15:0], halfw(w, 1'b0));
      chk(r[31:16], halfw(w, 1'b1));
    end
    $display("test words done");
    u_host.wr28(4'h3, 28'h000001e);
    u_host.wr28(4'hb, 28'h7ff0000);
    u_host.wr28(4'hc, 28'h2000000);
    chk(u_dut.u_regs.mem_r[3][15:0], 16'h001e);
    chk({4'h0, u_dut.u_regs.mem_r[11][27:16]}, 16'h07ff);
    chk({4'h0, u_dut.u_regs.mem_r[12][27:16]}, 16'h0200);
    u_host.wr28(HBW_ADR_CFG4, 28'h6400300);
    for (int s = 0; s < 2; s++)
    begin
      u_host.wr28(HBW_ADR_CFG4, 28'h6000300);
      lfsr_r = lfsr_next(lfsr_r);
      m1 = {lfsr_r[6:0], lfsr_next(lfsr_r)};
      m2 = (s == 0) ? 23'h7fffff : {lfsr_r, 7'h55};
      meas_result1 <= m1;
      meas_result2 <= m2;
      meas_ready <= 1'b1;
      @(posedge clk);
      meas_ready <= 1'b0;
      repeat (30) @(posedge clk);
      chk({15'h0, buffer_empty_flag}, 16'h1);
      if (s == 0)
        u_host.wr28(HBW_ADR_CFG4, 28'h7000300);
      else
      begin
        alu_trigger_pin <= 1'b1;
        repeat (6) @(posedge clk);
        alu_trigger_pin <= 1'b0;
      end
      for (int k = 0; k < 300 && buffer_empty_flag !== 1'b0; k++)
        @(posedge clk);
      chk({15'h0, buffer_empty_flag}, 16'h0);
      u_host.rd28(HBW_ADR_FIFO1, r);
      chk(r[15:0], halfw({5'h0, m1}, 1'b0));
      chk(r[31:16], halfw({5'h0, m1}, 1'b1));
      u_host.rd28(HBW_ADR_FIFO2, r);
      chk(r[15:0], halfw({5'h0, m2}, 1'b0));
      chk(r[31:16], halfw({5'h0, m2}, 1'b1));
      n = mr_count;
      u_host.wr28(HBW_ADR_CFG4, 28'h6400300);
      chk(16'(mr_count - n), 16'h1);
      chk({15'h0, bus16_mode}, 16'h1);
      chk({15'h0, buffer_empty_flag}, 16'h1);
      $display("test shot %0d done", s);
    end
    final_report();
  end
endmodule
